// ===== iowd_cfg.svh
// constants for the i/o port watchdog: address, data codes, timing
`ifndef IOWD_CFG_SVH
`define IOWD_CFG_SVH
`define IOWD_PORT_ADDR 16'h0443
`define IOWD_ADDR_W 16
`define IOWD_DATA_W 8
`define IOWD_CMD_REFRESH 8'h01
`define IOWD_CMD_DISABLE 8'h00
`define IOWD_TIMEOUT_MS 1600
`define IOWD_CLK_MHZ 100
`define IOWD_TIMEOUT_CYC (`IOWD_TIMEOUT_MS * 1000 * `IOWD_CLK_MHZ)
`define IOWD_CNT_W 28
`define IOWD_RST_PULSE_CYC 16
`define IOWD_STAT_EN_BIT 0
`define IOWD_STAT_ACT_BIT 1
`define IOWD_STAT_FIRED_BIT 2
`endif

// ===== iowd_counter.sv
// interval counter with restart and terminal flag
`timescale 1ns/100ps
module iowd_counter #(
	parameter int CNT_W = 28,
	parameter logic [27:0] LIMIT = 28'h98_96800
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// control
	input wire logic run_i,
	input wire logic restart_i,
	// status
	output logic expired_o
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic expired;
	} iowd_cnt_st_t;
	iowd_cnt_st_t st;
	iowd_cnt_st_t next_st;

	initial begin
		if (CNT_W < 2 || CNT_W > 28 || LIMIT < 28'h2) begin
			$error("iowd_counter: unsupported width or limit");
		end
	end

	// count while running, expire at limit
	always_comb begin
		next_st = st;
		next_st.expired = 1'b0;
		if (restart_i || !run_i) begin
			next_st.cnt = '0;
		end else if (st.cnt == CNT_W'(LIMIT - 28'h1)) begin
			next_st.cnt = '0;
			next_st.expired = 1'b1;
		end else begin
			next_st.cnt = st.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign expired_o = st.expired;
endmodule

// ===== iowd_pkg.sv
// types for the i/o port watchdog
package iowd_pkg;
	typedef enum logic [1:0] {
		IOWD_IDLE = 2'b00,
		IOWD_RUN = 2'b01,
		IOWD_FIRED = 2'b10
	} iowd_state_t;
	typedef enum logic {
		IOWD_ACT_RESET = 1'b0,
		IOWD_ACT_IRQ = 1'b1
	} iowd_action_t;
endpackage

// ===== iowd_top.sv
// i/o port watchdog timer: port decode, arming, timeout action
// operation summary:
// - idle after reset; a read of the port arms the timer and restarts it
// - a write of 01h arms from any state and restarts the interval
// - a write of 00h drops back to idle and cancels a pending action
// - other write values are ignored, other addresses are not selected
// - on expiry the state moves to fired and the counter stops
// - reset action: cpu_rst_o pulses for RST_PULSE_CYC cycles, no re-arm
// - irq action: irq11_o holds until a read, a write 01h or a write 00h
// - a refresh landing in the expiry cycle wins over the timeout
// hazards:
// - the strap is taken once, on the first enabled edge after reset;
//   changing it later has no effect until the next system reset
// - ce_i low freezes the counter too, so the interval stretches with it
// - the status byte shows the state as it was before the read
`timescale 1ns/100ps
`include "iowd_cfg.svh"
module iowd_top #(
	parameter int CNT_W = `IOWD_CNT_W,
	parameter logic [27:0] TIMEOUT_CYC = 28'(`IOWD_TIMEOUT_CYC),
	parameter logic [15:0] PORT_ADDR = `IOWD_PORT_ADDR,
	parameter int RST_PULSE_CYC = `IOWD_RST_PULSE_CYC
) (
	// clock, reset, enable
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// i/o port access, one-cycle strobes
	input wire logic [`IOWD_ADDR_W-1:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [`IOWD_DATA_W-1:0] io_wdata_i,
	output logic [`IOWD_DATA_W-1:0] io_rdata_o,
	output logic io_sel_o,
	// configuration strap
	input wire logic act_irq_strap_i,
	// timeout actions
	output logic cpu_rst_o,
	output logic irq11_o
);
	typedef struct packed {
		iowd_pkg::iowd_state_t state;
		iowd_pkg::iowd_action_t action;
		logic strap_taken;
		logic [7:0] rst_cnt;
		logic cpu_rst;
		logic irq;
		logic [`IOWD_DATA_W-1:0] rdata;
	} iowd_st_t;
	iowd_st_t st;
	iowd_st_t next_st;
	logic hit;
	logic restart;
	logic expired;
	logic rd_hit;
	logic wr_hit;
	logic wr_one;
	logic wr_zero;

	// refuse parameter values the logic cannot serve
	initial begin
		if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > 255) begin
			$error("iowd_top: reset pulse length out of range");
		end
		if (CNT_W < 2 || CNT_W > 28) begin
			$error("iowd_top: counter width out of range");
		end
		if (TIMEOUT_CYC < 28'h2) begin
			$error("iowd_top: timeout too short");
		end
		if (CNT_W < 28 && (TIMEOUT_CYC >> CNT_W) != 28'h0) begin
			$error("iowd_top: timeout does not fit the counter");
		end
	end

	// status byte seen by a read: enabled, action, fired
	function automatic logic [`IOWD_DATA_W-1:0] status_byte(
		input iowd_pkg::iowd_state_t s,
		input iowd_pkg::iowd_action_t a);
		logic [`IOWD_DATA_W-1:0] b;
		b = '0;
		b[`IOWD_STAT_EN_BIT] = (s != iowd_pkg::IOWD_IDLE);
		b[`IOWD_STAT_ACT_BIT] = a;
		b[`IOWD_STAT_FIRED_BIT] = (s == iowd_pkg::IOWD_FIRED);
		return b;
	endfunction

	// port decode
	assign hit = (io_addr_i == PORT_ADDR);
	assign io_sel_o = hit && (io_rd_i || io_wr_i);
	assign rd_hit = hit && io_rd_i;
	assign wr_hit = hit && io_wr_i;
	assign wr_one = wr_hit && (io_wdata_i == `IOWD_CMD_REFRESH);
	assign wr_zero = wr_hit && (io_wdata_i == `IOWD_CMD_DISABLE);
	// reads and refresh writes both restart the interval
	assign restart = wr_one || rd_hit;

	iowd_counter #(
		.CNT_W(CNT_W),
		.LIMIT(TIMEOUT_CYC)
	) u_cnt (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.run_i(st.state == iowd_pkg::IOWD_RUN),
		.restart_i(restart),
		.expired_o(expired)
	);

	// next state
	always_comb begin
		next_st = st;
		// strap taken once after reset release
		if (!st.strap_taken) begin
			next_st.strap_taken = 1'b1;
			next_st.action = act_irq_strap_i ? iowd_pkg::IOWD_ACT_IRQ
				: iowd_pkg::IOWD_ACT_RESET;
		end
		if (st.rst_cnt != 8'h00) begin
			next_st.rst_cnt = st.rst_cnt - 8'h01;
		end
		next_st.cpu_rst = (next_st.rst_cnt != 8'h00);
		// read returns status
		if (rd_hit) begin
			next_st.rdata = status_byte(st.state, st.action);
		end
		// arming, expiry and clearing by port access
		unique case (st.state)
			iowd_pkg::IOWD_IDLE: begin
				if (rd_hit) begin
					next_st.state = iowd_pkg::IOWD_RUN;
				end
			end
			iowd_pkg::IOWD_RUN: begin
				if (expired && !restart) begin
					next_st.state = iowd_pkg::IOWD_FIRED;
					if (st.action == iowd_pkg::IOWD_ACT_RESET) begin
						next_st.rst_cnt = 8'(RST_PULSE_CYC);
						next_st.cpu_rst = 1'b1;
					end else begin
						next_st.irq = 1'b1;
					end
				end
			end
			iowd_pkg::IOWD_FIRED: begin
				// a read acknowledges the timeout and re-arms
				if (rd_hit) begin
					next_st.state = iowd_pkg::IOWD_RUN;
					next_st.irq = 1'b0;
				end
			end
			default: begin
				next_st.state = iowd_pkg::IOWD_IDLE;
			end
		endcase
		// writes: 1 refreshes and enables, 0 disables
		if (wr_hit) begin
			if (wr_one) begin
				next_st.state = iowd_pkg::IOWD_RUN;
				next_st.irq = 1'b0;
			end else if (wr_zero) begin
				next_st.state = iowd_pkg::IOWD_IDLE;
				next_st.irq = 1'b0;
				next_st.rst_cnt = 8'h00;
				next_st.cpu_rst = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st <= '{state: iowd_pkg::IOWD_IDLE, action: iowd_pkg::IOWD_ACT_RESET,
				strap_taken: 1'b0, rst_cnt: 8'h00, cpu_rst: 1'b0, irq: 1'b0,
				rdata: '0};
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// outputs from flops
	assign cpu_rst_o = st.cpu_rst;
	assign irq11_o = st.irq;
	assign io_rdata_o = st.rdata;
endmodule

// ===== iowd_top_props.sv
// assertions on the i/o port watchdog ports
`timescale 1ns/100ps
module iowd_props (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// port access and actions
	input wire logic [15:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic io_sel_o,
	input wire logic act_irq_strap_i,
	input wire logic cpu_rst_o,
	input wire logic irq11_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// decoded accesses
	wire at = io_addr_i == 16'h0443;
	wire rd = io_rd_i && at;
	wire wr1 = io_wr_i && at && io_wdata_i == 8'h01;
	wire wr0 = io_wr_i && at && io_wdata_i == 8'h00;
	wire fire = cpu_rst_o || irq11_o;
	a_sel_decode: assert property (io_sel_o == ((io_rd_i || io_wr_i) && at)) else $error("bad select");
	a_arm_fire: assert property ((rd || wr1) ##1 !io_sel_o [*8] |-> ##[0:2] fire) else $error("no timeout");
	a_no_early: assert property (wr1 |=> !fire [*6]) else $error("early timeout");
	a_off_quiet: assert property (wr0 |=> (!$rose(cpu_rst_o) && !irq11_o) [*8]) else $error("fired off");
	a_rst_pulse: assert property ($rose(cpu_rst_o) |-> cpu_rst_o [*4] ##1 !cpu_rst_o) else $error("pulse");
	a_rst_action: assert property ($rose(cpu_rst_o) |-> !act_irq_strap_i) else $error("wrong action");
	a_irq_action: assert property ($rose(irq11_o) |-> act_irq_strap_i) else $error("wrong action");
	a_irq_hold: assert property (irq11_o && !io_sel_o |=> irq11_o) else $error("irq dropped");
	a_read_act: assert property (rd |=> io_rdata_o[1] == act_irq_strap_i) else $error("status");
endmodule
bind iowd_top iowd_props u_iowd_props (.*);

// ===== iowd_top_tb_top.sv
// bench for the i/o port watchdog
`timescale 1ns/100ps
module iowd_top_tb_top;
	logic mclk_i = 0, srst_i = 1, io_rd_i = 0, io_wr_i = 0, act_irq_strap_i = 0;
	logic [15:0] io_addr_i = 16'h0000;
	logic [7:0] io_wdata_i = 8'h00, io_rdata_o;
	logic io_sel_o, cpu_rst_o, irq11_o;
	int miscompares = 0, n_tests = 0, cyc = 0, n;
	iowd_top #(.TIMEOUT_CYC(28'h0000008), .RST_PULSE_CYC(4)) u_iowd_top (.mclk_i(mclk_i),
		.srst_i(srst_i), .ce_i(1'b1), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
		.io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.io_sel_o(io_sel_o), .act_irq_strap_i(act_irq_strap_i), .cpu_rst_o(cpu_rst_o),
		.irq11_o(irq11_o));
	// clock and hang guard
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (++cyc == 3000) begin
			miscompares++;
			print_verdict;
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	// one-cycle port access
	task automatic acc(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		io_rd_i <= r;
		io_wr_i <= w;
		io_addr_i <= a;
		io_wdata_i <= d;
		#1;
		chk(io_sel_o, a == 16'h0443 && (r || w));
		@(posedge mclk_i);
		io_rd_i <= 0;
		io_wr_i <= 0;
		#1;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// both timeout actions in turn
	initial begin
		for (int s = 0; s < 2; s++) begin
			@(posedge mclk_i);
			srst_i <= 1;
			act_irq_strap_i <= s[0];
			repeat (4) @(posedge mclk_i);
			srst_i <= 0;
			acc(1, 0, 16'h0443, 8'h00);
			chk(io_rdata_o[1], s[0]);
			tick(4);
			acc(0, 1, 16'h0443, 8'h01);
			tick(5);
			chk(cpu_rst_o | irq11_o, 0);
			for (n = 5; n < 20 && !(cpu_rst_o | irq11_o); n++) tick(1);
			chk(n >= 7 && n <= 10, 1);
			chk(irq11_o, s[0]);
			chk(cpu_rst_o, !s[0]);
			tick(6);
			chk({cpu_rst_o, irq11_o}, s[0]);
			acc(0, 1, 16'h0443, 8'h01);
			chk(irq11_o, 0);
			acc(0, 1, 16'h0443, 8'h00);
			acc(0, 1, 16'h0443, 8'h02);
			acc(0, 1, 16'h0444, 8'h01);
			for (n = 0; n < 30 && !(cpu_rst_o | irq11_o); n++) tick(1);
			chk(8'(n), 8'h1E);
			acc(1, 0, 16'h0443, 8'h00);
			chk(io_rdata_o, {6'h00, s[0], 1'b0});
		end
		print_verdict;
	end
endmodule
